/* File: lcf_control.sv */
// Overview of operation
// RULE1 - data-only: allocate only for data cache; instruction misses never reload
// RULE2 - data-only plus instruction-only set: no new allocations at all
// RULE3 - writing one to global invalidate clears every line status
// RULE4 - software never sets global invalidate while cache is enabled
// RULE5 - sleep-pin control: low-power pin follows nap or sleep state
// RULE6 - software avoids sleep-pin control in nap with quiesce snooping
// RULE7 - write-through: writes go to bus, entries marked clean
// RULE8 - software never sets write-through after enabling the cache
// RULE9 - test support: flush and store pushes go only to cache, valid
// RULE10 - test support: no zero-block broadcast, single-beat store misses stay off bus
// RULE11 - two-bit output hold field selects ram output hold time
// RULE12 - delay-line slow bit lengthens every delay tap
// RULE13 - differential-clock bit enables late-write differential clocking
// RULE14 - delay-line bypass is reserved and written zero
// RULE15 - flush assist decides whether unmarked castouts allocate on miss
// RULE16 - software sets flush assist and clears instruction-only before flushing
// RULE17 - hardware flush walks indices of way 0 then way 1
// RULE18 - each visited index and way casts out every modified sector
// RULE19 - after the walk every tag line is invalidated
// RULE20 - l1 accesses blocked during flush while snoops still served
// RULE21 - hardware-flush bit clears once tags hold no valid entries
// RULE22 - software brackets the flush with syncs after stopping streams
// RULE23 - instruction-only: reload only for instruction cache transactions
// RULE24 - enable bit turns on operation from the next transaction
// RULE25 - hardware-flush bit reads one while walk is still running
//
// The APB slave port and the register offsets were decided locally.
module lcf_control
  import lcf_pkg::*;
#(
  parameter int INDEX_BITS = 6
)
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // power state pins
  input wire logic NAP_SLEEP_PIN,
  output logic CACHE_RAM_LOW_POWER,
  // l1 request and decision
  input lcf_req_type REQ,
  output lcf_dec_type DEC,
  // tag array port used by invalidate and flush
  output logic TAG_SEL,
  output logic TAG_WAY,
  output logic [INDEX_BITS-1:0] TAG_INDEX,
  output logic TAG_CLEAR_ALL,
  input wire logic [SECTORS-1:0] TAG_DIRTY,
  // castout request to the bus interface
  output logic CASTOUT_REQ,
  output logic [1:0] CASTOUT_SECTOR,
  input wire logic CASTOUT_ACK,
  // ram timing configuration
  output logic [1:0] OUTPUT_HOLD_SELECT,
  output logic DELAY_LINE_SLOW,
  output logic DIFFERENTIAL_CLOCK_SELECT
);

  logic [31:0] ctrl;
  logic nap_meta;
  logic nap_sync;
  logic ack_meta;
  logic ack_sync;
  logic inval_pulse;
  logic enabled;
  lcf_flush_type state;
  lcf_flush_type next_state;
  logic [INDEX_BITS-1:0] index;
  logic way;
  logic [SECTORS-1:0] pending;
  logic [1:0] sector;
  logic wr;
  logic hwf_start;
  logic walk_done;
  logic ack_q;
  logic ack_new;
  logic adv;

  assign wr = PSEL && PENABLE && PWRITE && (PADDR == CTRL_ADDR);
  assign hwf_start = wr && PWDATA[HWF_BIT] && !ctrl[HWF_BIT];
  assign walk_done = (state == FL_INVAL);
  // the acknowledge is a level held until our request drops; count only its rise
  assign ack_new = ack_sync && !ack_q;
  assign adv = (state == FL_WALK && !(|TAG_DIRTY)) || (state == FL_CAST && next_state != FL_CAST);

  // two-flop synchronisers for pin and bus-side acknowledge
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      nap_meta <= 1'b0;
      nap_sync <= 1'b0;
      ack_meta <= 1'b0;
      ack_sync <= 1'b0;
      ack_q <= 1'b0;
    end
    else
    begin
      nap_meta <= NAP_SLEEP_PIN;
      nap_sync <= nap_meta;
      ack_meta <= CASTOUT_ACK;
      ack_sync <= ack_meta;
      ack_q <= ack_sync;
    end
  end

  // control register; invalidate is self-clearing, flush bit cleared by hardware
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      ctrl <= CTRL_RESET;
    end
    else if (wr)
    begin
      ctrl <= PWDATA & CTRL_WMASK;
      ctrl[GI_BIT] <= 1'b0;
      ctrl[BYP_BIT] <= 1'b0; // reserved, kept zero [RULE14]
      // a write cannot clear a walk in progress; set from state wins
      ctrl[HWF_BIT] <= PWDATA[HWF_BIT] || (state != FL_IDLE && !walk_done); // [RULE25] [RULE21]
    end
    else if (walk_done)
    begin
      ctrl[HWF_BIT] <= 1'b0; // [RULE21]
    end
  end

  // global invalidate is a one-cycle strobe to the tag array
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
      inval_pulse <= 1'b0;
    else
      inval_pulse <= wr && PWDATA[GI_BIT]; // [RULE3]
  end

  // enable takes effect from the next request, never mid-transaction
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
      enabled <= 1'b0;
    else if (!REQ.valid)
      enabled <= ctrl[EN_BIT]; // [RULE24]
  end

  // flush walk state register
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
      state <= FL_IDLE;
    else
      state <= next_state;
  end

  // walk sequencing: visit index, cast modified sectors, advance
  always_comb
  begin
    next_state = state;
    case (state)
      FL_IDLE:
      begin
        if (hwf_start)
          next_state = FL_WALK; // [RULE17]
      end
      FL_WALK:
      begin
        if (|TAG_DIRTY)
          next_state = FL_CAST; // [RULE18]
        else if (way && (&index))
          next_state = FL_INVAL;
      end
      FL_CAST:
      begin
        if (ack_new && (pending == SECTORS'(1) << sector))
          next_state = (way && (&index)) ? FL_INVAL : FL_WALK;
      end
      FL_INVAL:
      begin
        next_state = FL_IDLE; // [RULE19]
      end
      default:
      begin
        next_state = FL_IDLE;
      end
    endcase
  end

  // index and way counters; way 0 fully, then way 1
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      index <= '0;
      way <= 1'b0;
    end
    else if (state == FL_IDLE)
    begin
      index <= '0;
      way <= 1'b0;
    end
    else if (adv)
    begin
      index <= index + 1'b1; // wraps to zero at the top [RULE17]
      if (&index)
        way <= 1'b1;
    end
  end

  // sector castout queue; acknowledge is a level held until the request drops
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
      pending <= '0;
    else if (state == FL_WALK)
      pending <= TAG_DIRTY;
    else if (state == FL_CAST && ack_new)
      pending <= pending & ~(SECTORS'(1) << sector); // [RULE18]
  end

  // lowest pending sector goes out first
  always_comb
  begin
    sector = 2'h0;
    for (int i = SECTORS - 1; i >= 0; i--)
      if (pending[i])
        sector = 2'(i);
  end

  // tag port and castout outputs
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      TAG_SEL <= 1'b0;
      TAG_WAY <= 1'b0;
      TAG_INDEX <= '0;
      TAG_CLEAR_ALL <= 1'b0;
      CASTOUT_REQ <= 1'b0;
      CASTOUT_SECTOR <= 2'h0;
    end
    else
    begin
      TAG_SEL <= (next_state == FL_WALK);
      // look up the line the counters hold after this edge, so dirty bits match it
      TAG_WAY <= (adv && (&index)) ? 1'b1 : way;
      TAG_INDEX <= adv ? index + 1'b1 : index;
      TAG_CLEAR_ALL <= (next_state == FL_INVAL) || (wr && PWDATA[GI_BIT]); // [RULE19] [RULE3]
      CASTOUT_REQ <= (state == FL_CAST) && !ack_sync && (|pending);
      CASTOUT_SECTOR <= sector;
    end
  end

  // low-power pin follows power state when sleep-pin control is set
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
      CACHE_RAM_LOW_POWER <= 1'b0;
    else
      CACHE_RAM_LOW_POWER <= ctrl[SP_BIT] && nap_sync; // [RULE5]
  end

  // ram timing fields driven straight from the register
  assign OUTPUT_HOLD_SELECT = ctrl[OH_LO+1:OH_LO]; // [RULE11]
  assign DELAY_LINE_SLOW = ctrl[SL_BIT]; // [RULE12]
  assign DIFFERENTIAL_CLOCK_SELECT = ctrl[DF_BIT]; // [RULE13]

  // allocation and bus policy; snoops are not routed here so they stay served
  always_comb
  begin
    logic alloc_ok;
    logic tspush;
    alloc_ok = 1'b1;
    tspush = ctrl[TS_BIT] && REQ.flush_push;
    if (ctrl[DO_BIT] && REQ.from_icache)
      alloc_ok = 1'b0; // [RULE1]
    if (ctrl[IO_BIT] && !REQ.from_icache)
      alloc_ok = 1'b0; // [RULE23]
    if (ctrl[DO_BIT] && ctrl[IO_BIT])
      alloc_ok = 1'b0; // [RULE2]
    if (REQ.castout && !REQ.castout_marker && !ctrl[FA_BIT])
      alloc_ok = 1'b0; // [RULE15]
    DEC.blocked = (state != FL_IDLE) && REQ.valid; // [RULE20]
    DEC.allocate = REQ.valid && enabled && !DEC.blocked && !REQ.hit && alloc_ok;
    DEC.mark_valid = tspush && enabled; // [RULE9]
    DEC.mark_dirty = REQ.is_write && !ctrl[WT_BIT] && !tspush; // [RULE7]
    DEC.write_bus = REQ.valid && !DEC.blocked
      && ((REQ.is_write && ctrl[WT_BIT]) || (REQ.flush_push && !ctrl[TS_BIT]))
      && !(ctrl[TS_BIT] && REQ.single_store && !REQ.hit); // [RULE7] [RULE10]
    DEC.broadcast = REQ.valid && REQ.zero_block && !ctrl[TS_BIT]; // [RULE10]
  end

  // apb read path; control word carries walk and invalidate state
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
      PRDATA <= 32'h0000_0000;
    else if (PSEL && !PENABLE && !PWRITE)
    begin
      if (PADDR == CTRL_ADDR)
      begin
        PRDATA <= ctrl;
        PRDATA[HWF_BIT] <= ctrl[HWF_BIT] || (state != FL_IDLE); // [RULE25]
        PRDATA[IP_BIT] <= inval_pulse;
      end
      else if (PADDR == STATUS_ADDR)
        PRDATA <= {29'h0, enabled, state};
      else
        PRDATA <= 32'h0000_0000;
    end
  end

  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && (PADDR != CTRL_ADDR) && (PADDR != STATUS_ADDR);

  // checks
  hwf_read_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (state != FL_IDLE) |-> ctrl[HWF_BIT] || $past(hwf_start)) // [RULE25]
    else $error("flush bit low during walk");
  hwf_clear_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    walk_done && !wr |=> !ctrl[HWF_BIT]) // [RULE21]
    else $error("flush bit not cleared");
  flush_start_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    hwf_start && state == FL_IDLE |=> state == FL_WALK && index == '0 && !way) // [RULE17]
    else $error("flush did not start at zero");
  block_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (state != FL_IDLE) && REQ.valid |-> DEC.blocked && !DEC.allocate) // [RULE20]
    else $error("l1 access during flush");
  inval_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    walk_done |-> TAG_CLEAR_ALL) // [RULE19]
    else $error("tags not cleared");
  gi_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    wr && PWDATA[GI_BIT] |=> TAG_CLEAR_ALL ##1 !ctrl[GI_BIT]) // [RULE3]
    else $error("invalidate missed");
  lock_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    ctrl[DO_BIT] && ctrl[IO_BIT] |-> !DEC.allocate) // [RULE2]
    else $error("allocation while locked");
  dataonly_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    ctrl[DO_BIT] && REQ.from_icache |-> !DEC.allocate) // [RULE1]
    else $error("instruction reload in data-only");
  wt_clean_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    ctrl[WT_BIT] |-> !DEC.mark_dirty) // [RULE7]
    else $error("dirty mark in write-through");
  zz_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    $rose(nap_sync) && ctrl[SP_BIT] ##1 ctrl[SP_BIT] |-> CACHE_RAM_LOW_POWER) // [RULE5]
    else $error("low-power pin missed");
  zb_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    ctrl[TS_BIT] |-> !DEC.broadcast) // [RULE10]
    else $error("zero-block broadcast in test mode");
  flush_c: cover property (@(posedge CORE_CLK) disable iff (RESET) hwf_start ##[1:1000] walk_done);
  cast_c: cover property (@(posedge CORE_CLK) disable iff (RESET) CASTOUT_REQ ##[1:20] ack_sync);
  zz_c: cover property (@(posedge CORE_CLK) disable iff (RESET) $rose(CACHE_RAM_LOW_POWER));
endmodule // lcf_control

/* File: lcf_pkg.sv */
package lcf_pkg;
  // register byte addresses on the apb slave
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  // field positions in the cache control word
  localparam int EN_BIT = 0;
  localparam int DO_BIT = 9;
  localparam int GI_BIT = 10;
  localparam int SP_BIT = 11;
  localparam int WT_BIT = 12;
  localparam int TS_BIT = 13;
  localparam int OH_LO = 14;
  localparam int SL_BIT = 16;
  localparam int DF_BIT = 17;
  localparam int BYP_BIT = 18;
  localparam int FA_BIT = 19;
  localparam int HWF_BIT = 20;
  localparam int IO_BIT = 21;
  localparam int IP_BIT = 31;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h003F_FE01;
  // sector geometry
  localparam int SECTORS = 4;
  localparam int SECTOR_BYTES = 32;
  // flush walk states
  typedef enum logic [1:0]
  {
    FL_IDLE = 2'b00,
    FL_WALK = 2'b01,
    FL_CAST = 2'b10,
    FL_INVAL = 2'b11
  } lcf_flush_type;
  // an allocation request from an l1 cache
  typedef struct packed
  {
    logic valid;
    logic from_icache;
    logic castout;
    logic castout_marker;
    logic flush_push;
    logic zero_block;
    logic single_store;
    logic is_write;
    logic hit;
  } lcf_req_type;
  // decision handed back to the cache datapath
  typedef struct packed
  {
    logic allocate;
    logic write_bus;
    logic mark_dirty;
    logic mark_valid;
    logic broadcast;
    logic blocked;
  } lcf_dec_type;
endpackage

/* File: lcf_far_model.sv */
module lcf_far_model
  import lcf_pkg::*;
#(
  parameter int INDEX_BITS = 2
)
(
  // clock
  input wire logic clk,
  // tag array port
  input wire logic tag_sel,
  input wire logic tag_way,
  input wire logic [INDEX_BITS-1:0] tag_index,
  output logic [SECTORS-1:0] tag_dirty,
  // castout handshake of the bus interface
  input wire logic castout_req,
  input wire logic slow,
  output logic castout_ack = 1'b0,
  output int castouts
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flip = 1'b0;
  logic req_q = 1'b0;
  int wait_n = 0;
  always_ff @(posedge clk)
    flip <= ~flip;
  // odd lines of way 1 hold dirty sectors 0 and 2; a deselected port moves so stale reads show
  always_comb
    tag_dirty = tag_sel ? ((tag_way && tag_index[0]) ? 4'h5 : 4'h0) : {4{flip}};
  // ack after a short or long wait, dropped only once the request is gone
  always_ff @(posedge clk)
  begin
    if (!castout_req)
    begin
      castout_ack <= 1'b0;
      wait_n <= 0;
    end
    else if (wait_n >= (slow ? 6 : 0))
      castout_ack <= 1'b1;
    else
      wait_n <= wait_n + 1;
  end
  // one castout counted for each new request
  always_ff @(posedge clk)
  begin
    req_q <= castout_req;
    if (castout_req && !req_q)
      castouts <= castouts + 1;
  end
endmodule // lcf_far_model

/* File: testbench.sv */
module testbench
  import lcf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic CORE_CLK = 1'b0;
  logic RESET = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic NAP_SLEEP_PIN = 1'b0;
  logic SLOW = 1'b0;
  lcf_req_type REQ = '0;
  lcf_dec_type DEC;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, CACHE_RAM_LOW_POWER, TAG_SEL, TAG_WAY, TAG_CLEAR_ALL;
  logic CASTOUT_REQ, CASTOUT_ACK, DELAY_LINE_SLOW, DIFFERENTIAL_CLOCK_SELECT;
  logic [1:0] TAG_INDEX, CASTOUT_SECTOR, OUTPUT_HOLD_SELECT;
  logic [SECTORS-1:0] TAG_DIRTY;
  logic [3:0] last = 4'hF;
  logic co_q = 1'b0;
  logic cleared = 1'b0;
  int castouts, vis, co_n, n_fail, comparisons;
  always #5 CORE_CLK = ~CORE_CLK;
  lcf_control #(.INDEX_BITS(2)) dut (.CORE_CLK(CORE_CLK), .RESET(RESET), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .NAP_SLEEP_PIN(NAP_SLEEP_PIN),
    .CACHE_RAM_LOW_POWER(CACHE_RAM_LOW_POWER), .REQ(REQ), .DEC(DEC), .TAG_SEL(TAG_SEL),
    .TAG_WAY(TAG_WAY), .TAG_INDEX(TAG_INDEX), .TAG_CLEAR_ALL(TAG_CLEAR_ALL),
    .TAG_DIRTY(TAG_DIRTY), .CASTOUT_REQ(CASTOUT_REQ), .CASTOUT_SECTOR(CASTOUT_SECTOR),
    .CASTOUT_ACK(CASTOUT_ACK), .OUTPUT_HOLD_SELECT(OUTPUT_HOLD_SELECT),
    .DELAY_LINE_SLOW(DELAY_LINE_SLOW), .DIFFERENTIAL_CLOCK_SELECT(DIFFERENTIAL_CLOCK_SELECT));
  lcf_far_model #(.INDEX_BITS(2)) far (.clk(CORE_CLK), .tag_sel(TAG_SEL), .tag_way(TAG_WAY),
    .tag_index(TAG_INDEX), .tag_dirty(TAG_DIRTY), .castout_req(CASTOUT_REQ), .slow(SLOW),
    .castout_ack(CASTOUT_ACK), .castouts(castouts));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task give_verdict;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // one apb transfer, held until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] d, output logic e);
    int n;
    n = 0;
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge CORE_CLK);
      n++;
    end
    while (PREADY !== 1'b1);
    d = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task wr(input logic [31:0] v);
    logic [31:0] d;
    logic e;
    apb(1'b1, CTRL_ADDR, v, d, e);
  endtask
  task rd(output logic [31:0] d);
    logic e;
    apb(1'b0, CTRL_ADDR, 32'h0, d, e);
  endtask
  // walk order, clear pulse and sector order seen on the tag and castout ports
  always @(posedge CORE_CLK)
  begin
    if (TAG_SEL === 1'b1 && {1'b0, TAG_WAY, TAG_INDEX} != last)
    begin
      chk("visit", vis, {TAG_WAY, TAG_INDEX});
      last = {1'b0, TAG_WAY, TAG_INDEX};
      vis++;
    end
    if (TAG_CLEAR_ALL === 1'b1)
      cleared = 1'b1;
    if (CASTOUT_REQ === 1'b1 && co_q === 1'b0)
    begin
      chk("sector", co_n[0] ? 2 : 0, CASTOUT_SECTOR);
      co_n++;
    end
    co_q = CASTOUT_REQ;
  end
  task t_regs;
    logic [31:0] d;
    logic e;
    rd(d);
    chk("ctrl reset", CTRL_RESET, d);
    wr(32'h002B_FA00);
    rd(d);
    chk("ctrl readback", 32'h002B_FA00, d);
    @(negedge CORE_CLK);
    chk("ram timing", 4'hF, {OUTPUT_HOLD_SELECT, DELAY_LINE_SLOW, DIFFERENTIAL_CLOCK_SELECT});
    wr(32'h0000_4000);
    @(negedge CORE_CLK);
    chk("ram timing", 4'h4, {OUTPUT_HOLD_SELECT, DELAY_LINE_SLOW, DIFFERENTIAL_CLOCK_SELECT});
    apb(1'b0, 8'h08, 32'h0, d, e);
    chk("unmapped error", 1, e);
    chk("unmapped data", 0, d);
    wr(32'h0000_0400);
    repeat (4) @(posedge CORE_CLK);
    chk("invalidate pulse", 1, cleared);
    rd(d);
    chk("invalidate self clear", 0, d[GI_BIT]);
  endtask
  task wlp(input logic v);
    int n;
    n = 0;
    @(negedge CORE_CLK);
    while (CACHE_RAM_LOW_POWER !== v && n < 8)
    begin
      @(negedge CORE_CLK);
      n++;
    end
    chk("low power pin", v, CACHE_RAM_LOW_POWER);
  endtask
  task t_sleep;
    wr(32'h0000_0800);
    NAP_SLEEP_PIN <= 1'b1;
    wlp(1'b1);
    NAP_SLEEP_PIN <= 1'b0;
    wlp(1'b0);
    wr(32'h0);
    NAP_SLEEP_PIN <= 1'b1;
    repeat (6) @(posedge CORE_CLK);
    chk("pin unmanaged", 0, CACHE_RAM_LOW_POWER);
    NAP_SLEEP_PIN <= 1'b0;
  endtask
  // mode set from disabled, then one request and the masked decision
  task pol(input logic [31:0] c, input logic [8:0] r, input logic [5:0] m, input logic [5:0] e);
    wr(32'h0);
    wr(c);
    @(posedge CORE_CLK);
    REQ <= r;
    @(negedge CORE_CLK);
    chk("decision", e, DEC & m);
    @(posedge CORE_CLK);
    REQ <= '0;
  endtask
  task t_flush(input logic s, input int exp_co);
    logic [31:0] d;
    int n;
    SLOW <= s;
    vis = 0;
    last = 4'hF;
    cleared = 1'b0;
    wr(32'h0010_0000);
    REQ <= 9'h100;
    rd(d);
    chk("flush busy", 1, d[HWF_BIT]);
    chk("l1 blocked", 1, DEC.blocked);
    n = 0;
    while (d[HWF_BIT] !== 1'b0 && n < 300)
    begin
      rd(d);
      n++;
    end
    chk("flush bit", 0, d[HWF_BIT]);
    chk("visits", 8, vis);
    chk("tags cleared", 1, cleared);
    chk("castouts", exp_co, castouts);
    @(negedge CORE_CLK);
    chk("l1 unblocked", 0, DEC.blocked);
    REQ <= '0;
  endtask
  initial
  begin
    repeat (8) @(posedge CORE_CLK);
    RESET <= 1'b0;
    t_regs;
    t_sleep;
    pol(32'h0000_0201, 9'h180, 6'h20, 6'h00);
    pol(32'h0000_0201, 9'h100, 6'h20, 6'h20);
    pol(32'h0020_0201, 9'h100, 6'h20, 6'h00);
    pol(32'h0020_0001, 9'h100, 6'h20, 6'h00);
    pol(32'h0020_0001, 9'h180, 6'h20, 6'h20);
    pol(32'h0000_0000, 9'h100, 6'h20, 6'h00);
    pol(32'h0000_1001, 9'h103, 6'h18, 6'h10);
    pol(32'h0000_0001, 9'h103, 6'h18, 6'h08);
    pol(32'h0000_2001, 9'h111, 6'h14, 6'h04);
    pol(32'h0000_2001, 9'h108, 6'h02, 6'h00);
    pol(32'h0000_0001, 9'h108, 6'h02, 6'h02);
    pol(32'h0000_3001, 9'h106, 6'h10, 6'h00);
    pol(32'h0000_0001, 9'h140, 6'h20, 6'h00);
    pol(32'h0008_0001, 9'h140, 6'h20, 6'h20);
    wr(32'h0);
    t_flush(1'b1, 4);
    t_flush(1'b0, 8);
    give_verdict;
  end
  // watchdog well beyond the expected run length
  initial
  begin
    #500000;
    n_fail++;
    give_verdict;
  end
endmodule // testbench
